//--- common/gpc_pkg.sv
/*
 pin control package: register map, field layout, reset values,
 function codes and the carrier structs of the routed signals.
 assumes one 16-bit register bus and one clock domain.
*/
package gpc_pkg;

	// register byte addresses
	localparam logic [15:0] GPC_CTRL_OFFSET   = 16'h4043;
	localparam logic [15:0] GPC_LEVEL_OFFSET  = 16'h4044;
	localparam logic [15:0] GPC_STATUS_OFFSET = 16'h4045;

	// control field positions
	localparam int GPC_DIR_BIT   = 15;
	localparam int GPC_PULL_HI   = 14;
	localparam int GPC_PULL_LO   = 13;
	localparam int GPC_EDGE_BIT  = 12;
	localparam int GPC_SUPPLY_BIT = 11;
	localparam int GPC_POL_BIT   = 10;
	localparam int GPC_OD_BIT    = 9;
	localparam int GPC_ENA_BIT   = 7;
	localparam int GPC_FN_HI     = 3;
	localparam int GPC_FN_LO     = 0;

	// reset value and implemented bits of the control register
	localparam logic [15:0] GPC_CTRL_RESET = 16'ha400;
	localparam logic [15:0] GPC_CTRL_MASK  = 16'hfe8f;
	localparam logic [15:0] GPC_ZERO       = 16'h0000;

	// pull encodings
	localparam logic [1:0] GPC_PULL_NONE = 2'h0;
	localparam logic [1:0] GPC_PULL_DOWN = 2'h1;
	localparam logic [1:0] GPC_PULL_UP   = 2'h2;

	// input function codes
	typedef enum logic [3:0] {
		GPC_IN_PLAIN_LONG  = 4'h0,
		GPC_IN_PLAIN       = 4'h1,
		GPC_IN_ON_OFF      = 4'h2,
		GPC_IN_SLEEP_WAKE  = 4'h3,
		GPC_IN_SLEEP_WAKE_L = 4'h4,
		GPC_IN_SLEEP       = 4'h5,
		GPC_IN_POWER_ON    = 4'h6,
		GPC_IN_WATCHDOG    = 4'h7,
		GPC_IN_VSCALE1     = 4'h8,
		GPC_IN_VSCALE2     = 4'h9,
		GPC_IN_HW_EN1      = 4'ha,
		GPC_IN_HW_EN2      = 4'hb,
		GPC_IN_HW_CTL1     = 4'hc,
		GPC_IN_HW_CTL2     = 4'hd,
		GPC_IN_HW_CTL1_L   = 4'he,
		GPC_IN_HW_CTL2_L   = 4'hf
	} gpc_in_fn_type;

	// signals routed from the pin into the device
	typedef struct packed {
		logic plain_level;
		logic power_on_off_req;
		logic sleep_wake_req;
		logic sleep_req;
		logic power_on_req;
		logic watchdog_reset;
		logic voltage_scale_select_one;
		logic voltage_scale_select_two;
		logic hw_enable_one;
		logic hw_enable_two;
		logic hw_control_one;
		logic hw_control_two;
	} gpc_route_type;

	// device signals that may be driven out, bit index = output code
	typedef struct packed {
		logic aux_reset;            // 15
		logic ext_power_clock;      // 14
		logic converter_power_good; // 13
		logic system_supply_good;   // 12
		logic ext_power_enable_two; // 11
		logic ext_power_enable_one; // 10
		logic scale_done_two;       // 9
		logic scale_done_one;       // 8
		logic [2:0] unused_codes;   // 7..5, reserved, read as low
		logic power_state_change;   // 4
		logic sleep_state;          // 3
		logic on_state;             // 2
		logic osc_clock;            // 1
		logic unused_level;         // 0, replaced by the level register
	} gpc_source_type;

endpackage

//--- logic/gpc_pin_control.sv
/*
 single pin control: control register, pad drive, pull and supply
 select, input routing and edge event detection.
 assumes the register master and the source signals share CLK_SYS;
 PIN_IN is asynchronous and is synchronised here.
*/
// Overview of operation
// - bit 15 direction, one means input
// - bits 14:13 choose pull, default pull-down
// - single edge follows polarity setting
// - edge mode one fires on both edges
// - bit 11 picks pad supply domain
// - bit 10 zero inverts pin signal
// - bit 9 open drain drives low only
// - bit 7 zero tri-states the pin
// - input codes 0,1 plain, debounce differs
// - input codes 2-6 power requests
// - input 7 watchdog, 8-9 voltage scaling
// - input 10-15 hardware enables and controls
// - output 0 level register, 1 oscillator
// - output 2-4 state indications, 5-7 reserved
// - output 8-11 scaling done, power enables
// - output 12-13 supply and power good
// - output 14 power clock, 15 aux reset
module gpc_pin_control (
	// clock, reset, enable
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST_B,
	input  wire logic                   CE,
	// register port
	input  wire logic [15:0]            REG_ADDR,
	input  wire logic [15:0]            REG_WDATA,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	output logic      [15:0]            REG_RDATA,
	// pad
	input  wire logic                   PIN_IN,
	output logic                        PIN_OUT,
	output logic                        PIN_OE,
	output logic                        PULL_UP_EN,
	output logic                        PULL_DOWN_EN,
	output logic                        SUPPLY_SEL,
	// device side
	input  wire gpc_pkg::gpc_source_type SRC,
	output gpc_pkg::gpc_route_type      ROUTE,
	output logic                        LONG_DEBOUNCE,
	output logic                        PIN_EVENT
);
	import gpc_pkg::*;

	logic [15:0]    ctrl_reg;
	logic           level_reg;
	logic [15:0]    rdata_reg;
	logic           sync1_reg;
	logic           sync2_reg;
	logic           prev_reg;
	logic           pin_out_reg;
	logic           pin_oe_reg;
	logic           pull_up_reg;
	logic           pull_down_reg;
	logic           supply_reg;
	gpc_route_type  route_reg;
	gpc_route_type  route_next;
	logic           long_db_reg;
	logic           long_db_next;
	logic           event_reg;
	logic           event_next;
	logic           pin_out_next;
	logic           pin_oe_next;

	logic           is_input;
	logic           enabled;
	logic           pol;
	logic [3:0]     fn;
	logic [1:0]     pull;
	logic           in_level;
	logic           src_level;
	logic           drive_level;
	logic [15:0]    src_vec;

	assign is_input = ctrl_reg[GPC_DIR_BIT];
	assign enabled  = ctrl_reg[GPC_ENA_BIT];
	assign pol      = ctrl_reg[GPC_POL_BIT];
	assign fn       = ctrl_reg[GPC_FN_HI:GPC_FN_LO];
	assign pull     = ctrl_reg[GPC_PULL_HI:GPC_PULL_LO];

	// control register, only implemented bits are kept
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			ctrl_reg <= GPC_CTRL_RESET;
		end else if (CE && REG_WR && REG_ADDR == GPC_CTRL_OFFSET) begin
			ctrl_reg <= REG_WDATA & GPC_CTRL_MASK;
		end
	end

	// output level register for the plain output code
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			level_reg <= 1'b0;
		end else if (CE && REG_WR && REG_ADDR == GPC_LEVEL_OFFSET) begin
			level_reg <= REG_WDATA[0];
		end
	end

	// read data stands one cycle after the strobe, else zero
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			rdata_reg <= GPC_ZERO;
		end else if (CE) begin
			rdata_reg <= GPC_ZERO;
			if (REG_RD) begin
				unique case (REG_ADDR)
					GPC_CTRL_OFFSET: begin
						rdata_reg <= ctrl_reg;
					end
					GPC_LEVEL_OFFSET: begin
						rdata_reg <= {15'h0000, level_reg};
					end
					GPC_STATUS_OFFSET: begin
						rdata_reg <= {15'h0000, sync2_reg};
					end
					default: begin
						rdata_reg <= GPC_ZERO;
					end
				endcase
			end
		end
	end

	// two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else if (CE) begin
			sync1_reg <= PIN_IN;
			sync2_reg <= sync1_reg;
		end
	end

	// edge history tracks while off, so enabling makes no edge
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			prev_reg <= 1'b0;
		end else if (CE) begin
			prev_reg <= in_level;
		end
	end

	// polarity applied to the sampled pin
	assign in_level = sync2_reg ^ ~pol;

	// edge event, only meaningful while the pin listens
	always_comb begin
		event_next = 1'b0;
		if (is_input && enabled) begin
			if (ctrl_reg[GPC_EDGE_BIT]) begin
				event_next = in_level ^ prev_reg;
			end else begin
				event_next = in_level & ~prev_reg;
			end
		end
	end

	// input routing; a tri-stated pin requests nothing
	always_comb begin
		route_next   = '0;
		long_db_next = 1'b0;
		if (is_input && enabled) begin
			unique case (gpc_in_fn_type'(fn))
				GPC_IN_PLAIN_LONG: begin
					route_next.plain_level = in_level;
					long_db_next = 1'b1;
				end
				GPC_IN_PLAIN: begin
					route_next.plain_level = in_level;
				end
				GPC_IN_ON_OFF: begin
					route_next.power_on_off_req = in_level;
				end
				GPC_IN_SLEEP_WAKE: begin
					route_next.sleep_wake_req = in_level;
				end
				GPC_IN_SLEEP_WAKE_L: begin
					route_next.sleep_wake_req = in_level;
					long_db_next = 1'b1;
				end
				GPC_IN_SLEEP: begin
					route_next.sleep_req = in_level;
				end
				GPC_IN_POWER_ON: begin
					route_next.power_on_req = in_level;
				end
				GPC_IN_WATCHDOG: begin
					route_next.watchdog_reset = in_level;
				end
				GPC_IN_VSCALE1: begin
					route_next.voltage_scale_select_one = in_level;
				end
				GPC_IN_VSCALE2: begin
					route_next.voltage_scale_select_two = in_level;
				end
				GPC_IN_HW_EN1: begin
					route_next.hw_enable_one = in_level;
				end
				GPC_IN_HW_EN2: begin
					route_next.hw_enable_two = in_level;
				end
				GPC_IN_HW_CTL1: begin
					route_next.hw_control_one = in_level;
				end
				GPC_IN_HW_CTL2: begin
					route_next.hw_control_two = in_level;
				end
				GPC_IN_HW_CTL1_L: begin
					route_next.hw_control_one = in_level;
					long_db_next = 1'b1;
				end
				GPC_IN_HW_CTL2_L: begin
					route_next.hw_control_two = in_level;
					long_db_next = 1'b1;
				end
			endcase
		end
	end

	// output source select; reserved codes stay low
	always_comb begin
		src_vec      = SRC;
		src_vec[0]   = level_reg;
		src_vec[7:5] = 3'h0;
		src_level    = src_vec[fn];
	end

	assign drive_level = src_level ^ ~pol;

	// pad drive
	always_comb begin
		pin_out_next = 1'b0;
		pin_oe_next  = 1'b0;
		if (!is_input && enabled) begin
			if (ctrl_reg[GPC_OD_BIT]) begin
				pin_out_next = 1'b0;
				pin_oe_next  = ~drive_level;
			end else begin
				pin_out_next = drive_level;
				pin_oe_next  = 1'b1;
			end
		end
	end

	// registered pad controls; costs one cycle of latency on clocks
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			pin_out_reg <= 1'b0;
			pin_oe_reg  <= 1'b0;
		end else if (CE) begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg  <= pin_oe_next;
		end
	end

	// pull and supply select, static between writes
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			pull_up_reg   <= 1'b0;
			pull_down_reg <= 1'b1;
			supply_reg    <= 1'b0;
		end else if (CE) begin
			pull_up_reg   <= (pull == GPC_PULL_UP);
			pull_down_reg <= (pull == GPC_PULL_DOWN);
			supply_reg    <= ctrl_reg[GPC_SUPPLY_BIT];
		end
	end

	// registered routing
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			route_reg   <= '0;
			long_db_reg <= 1'b0;
		end else if (CE) begin
			route_reg   <= route_next;
			long_db_reg <= long_db_next;
		end
	end

	// registered event pulse
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			event_reg <= 1'b0;
		end else if (CE) begin
			event_reg <= event_next;
		end
	end

	assign REG_RDATA     = rdata_reg;
	assign PIN_OUT       = pin_out_reg;
	assign PIN_OE        = pin_oe_reg;
	assign PULL_UP_EN    = pull_up_reg;
	assign PULL_DOWN_EN  = pull_down_reg;
	assign SUPPLY_SEL    = supply_reg;
	assign ROUTE         = route_reg;
	assign LONG_DEBOUNCE = long_db_reg;
	assign PIN_EVENT     = event_reg;

endmodule // gpc_pin_control

//--- verification/gpc_pin_control_props.sv
/*
 checker for the pin control block ports.
 assumes bind onto gpc_pin_control, CE held high.
*/
module gpc_pin_control_props
	import gpc_pkg::*;
(
	// clock, reset, enable
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	input wire logic        CE,
	// register port
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_RDATA,
	// pad and event
	input wire logic        PIN_OUT,
	input wire logic        PIN_OE,
	input wire logic        PULL_UP_EN,
	input wire logic        PULL_DOWN_EN,
	input wire logic        SUPPLY_SEL,
	input wire logic        PIN_EVENT
);
	timeunit 1ns;
	timeprecision 100ps;
	// last written edge mode and its one-cycle-old copy: both-edge mode may pulse back to back
	logic both_reg;
	logic both_old_reg;
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			both_reg     <= GPC_CTRL_RESET[GPC_EDGE_BIT];
			both_old_reg <= GPC_CTRL_RESET[GPC_EDGE_BIT];
		end else begin
			both_old_reg <= both_reg;
			if (CE && REG_WR && REG_ADDR == GPC_CTRL_OFFSET) begin
				both_reg <= REG_WDATA[GPC_EDGE_BIT];
			end
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// control write, then a quiet cycle so pads settle on it alone
	sequence s_set(c);
		CE && REG_WR && REG_ADDR == GPC_CTRL_OFFSET && c ##1 CE && !REG_WR;
	endsequence
	property p_rd_idle;
		CE && !REG_RD |=> REG_RDATA == 16'h0;
	endproperty
	property p_rd_back;
		s_set(1'b1) ##0 (REG_RD && REG_ADDR == GPC_CTRL_OFFSET)
			|=> REG_RDATA == ($past(REG_WDATA, 2) & GPC_CTRL_MASK);
	endproperty
	property p_pull;
		s_set(1'b1) |-> ##1 PULL_UP_EN == ($past(REG_WDATA[14:13], 2) == 2'h2)
			&& PULL_DOWN_EN == ($past(REG_WDATA[14:13], 2) == 2'h1);
	endproperty
	property p_supply;
		s_set(1'b1) |-> ##1 SUPPLY_SEL == $past(REG_WDATA[11], 2);
	endproperty
	property p_tri;
		s_set(!REG_WDATA[7]) |-> ##1 !PIN_OE;
	endproperty
	property p_input;
		s_set(REG_WDATA[15]) |-> ##1 !PIN_OE;
	endproperty
	property p_od;
		s_set(!REG_WDATA[15] && REG_WDATA[9] && REG_WDATA[7]) |-> ##1 !PIN_OUT;
	endproperty
	property p_event;
		PIN_EVENT && CE && !both_reg && !both_old_reg |=> !PIN_EVENT;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_rd_back: assert property (p_rd_back) else $error("readback wrong");
	a_pull: assert property (p_pull) else $error("pull enables wrong");
	a_supply: assert property (p_supply) else $error("supply select wrong");
	a_tri: assert property (p_tri) else $error("pin driven while off");
	a_input: assert property (p_input) else $error("input pin driven");
	a_od: assert property (p_od) else $error("open drain drove high");
	a_event: assert property (p_event) else $error("event longer than a cycle");
endmodule // gpc_pin_control_props

bind gpc_pin_control gpc_pin_control_props u_props (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
	.CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
	.PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .SUPPLY_SEL(SUPPLY_SEL),
	.PIN_EVENT(PIN_EVENT));

//--- verification/gpc_pin_control_test.sv
/*
 self-checking bench for the pin control block.
 assumes the peer model and the bound checker.
*/
module gpc_pin_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	import gpc_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata, n_ev;
	logic pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, supply_sel, long_debounce, pin_event;
	logic drive_en = 1'b0, drive_lvl = 1'b0;
	gpc_source_type src = '0;
	gpc_route_type route;
	int n_mismatch = 0, n_checks = 0;
	// ctrl, then oe out pull_up pull_down supply
	logic [20:0] rows [7] = '{{16'ha400, 5'b00010}, {16'h45f0, 5'b10100},
		{16'h0080, 5'b11000}, {16'h6880, 5'b11001}, {16'h0680, 5'b10000},
		{16'h0280, 5'b00000}, {16'h0600, 5'b00000}};
	int idx [16] = '{11, 11, 10, 9, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 1, 0};
	always #12.5 clk_sys = ~clk_sys;
	gpc_pin_control u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_UP_EN(pull_up_en),
		.PULL_DOWN_EN(pull_down_en), .SUPPLY_SEL(supply_sel), .SRC(src), .ROUTE(route),
		.LONG_DEBOUNCE(long_debounce), .PIN_EVENT(pin_event));
	gpc_pin_peer u_peer (.CLK_SYS(clk_sys), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PULL_UP_EN(pull_up_en), .PULL_DOWN_EN(pull_down_en), .drive_en(drive_en),
		.drive_lvl(drive_lvl), .PIN_IN(pin_in));
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bus tasks start at a rising edge
	task automatic wr(logic [15:0] a, logic [15:0] d, logic back);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= back;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		if (back) chk(reg_rdata, d & 16'hfe8f);
	endtask
	task automatic rd(logic [15:0] a, logic [15:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, e);
		@(posedge clk_sys);
	endtask
	// quiet gap first: a polarity change alone may flip the level
	task automatic pin(logic lvl, logic [15:0] exp);
		repeat (4) @(posedge clk_sys);
		drive_en <= 1'b1;
		drive_lvl <= lvl;
		n_ev = 16'h0;
		repeat (6) @(negedge clk_sys) n_ev += pin_event;
		chk(n_ev, exp);
		@(posedge clk_sys);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk_sys);
		chk({pin_oe, pull_up_en, pull_down_en, supply_sel}, 16'h2);
		@(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(GPC_CTRL_OFFSET, 16'ha400);
		rd(16'h4046, 16'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(GPC_CTRL_OFFSET, rows[i][20:5], 1'b1);
			chk({pin_oe, pin_out, pull_up_en, pull_down_en, supply_sel}, rows[i][4:0]);
			@(posedge clk_sys);
		end
		$display("pad table done");
		for (int c = 0; c < 32; c++) begin
			src <= gpc_source_type'(c[4] ? ~(16'h1 << c[3:0]) : 16'h1 << c[3:0]);
			wr(GPC_CTRL_OFFSET, 16'h0480 | c[3:0], 1'b0);
			chk(pin_out, !c[4] && c[3:0] inside {[1:4], [8:15]});
			@(posedge clk_sys);
		end
		src <= '0;
		wr(GPC_CTRL_OFFSET, 16'h0480, 1'b0);
		@(posedge clk_sys);
		wr(GPC_LEVEL_OFFSET, 16'h1, 1'b0);
		chk(pin_out, 1'b1);
		@(posedge clk_sys);
		rd(GPC_LEVEL_OFFSET, 16'h1);
		$display("output codes done");
		drive_en <= 1'b1;
		drive_lvl <= 1'b1;
		for (int c = 0; c < 16; c++) begin
			wr(GPC_CTRL_OFFSET, 16'h8480 | c[3:0], 1'b0);
			chk(16'({long_debounce, route}), 16'({c inside {0, 4, 14, 15}, 12'h1 << idx[c]}));
			@(posedge clk_sys);
		end
		wr(GPC_CTRL_OFFSET, 16'h8401, 1'b0);
		chk(16'(route), 16'h0);
		@(posedge clk_sys);
		rd(GPC_STATUS_OFFSET, 16'h1);
		$display("input codes done");
		wr(GPC_CTRL_OFFSET, 16'h8481, 1'b0);
		pin(1'b0, 16'h0);
		pin(1'b1, 16'h1);
		wr(GPC_CTRL_OFFSET, 16'h8081, 1'b0);
		pin(1'b0, 16'h1);
		pin(1'b1, 16'h0);
		wr(GPC_CTRL_OFFSET, 16'h9481, 1'b0);
		pin(1'b0, 16'h1);
		pin(1'b1, 16'h1);
		$display("event test done");
		rst_b <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({pin_oe, pull_up_en, pull_down_en, supply_sel}, 16'h2);
		@(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(GPC_CTRL_OFFSET, GPC_CTRL_RESET);
		chk(16'(route), 16'h0);
		$display("mid-run reset done");
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		report_and_stop();
	end
endmodule // gpc_pin_control_test

//--- verification/gpc_pin_peer.sv
/*
 far side logic on the pin: resolves the wire level.
 assumes pad outputs from the block, drive from the bench.
*/
module gpc_pin_peer (
	// clock
	input wire logic  CLK_SYS,
	// pad from block
	input wire logic  PIN_OUT,
	input wire logic  PIN_OE,
	input wire logic  PULL_UP_EN,
	input wire logic  PULL_DOWN_EN,
	// far side drive
	input wire logic  drive_en,
	input wire logic  drive_lvl,
	// wire level
	output logic      PIN_IN
);
	timeunit 1ns;
	timeprecision 100ps;
	// floating wire toggles so no value is trusted
	logic float_reg = 1'b0;
	always_ff @(posedge CLK_SYS) begin
		float_reg <= !float_reg;
	end
	always_comb begin
		PIN_IN = PIN_OE ? PIN_OUT : drive_en ? drive_lvl :
			PULL_UP_EN ? 1'b1 : PULL_DOWN_EN ? 1'b0 : float_reg;
	end
endmodule // gpc_pin_peer
